// ==== tb/core_dma_model.sv ====
`timescale 1ns/1ps
module core_dma_model (
  // clock, reset and bench commands
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic [2:0] go_in,
  // requests toward the block
  output logic            wait_int_out,
  output logic            wait_evt_out,
  output logic            dma_done_out
);
  // ----------------
  // core and dma pulses
  // ----------------
  // one cycle late on purpose: a core retires its wait instruction on an edge
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {dma_done_out, wait_evt_out, wait_int_out} <= 3'h0;
    end else begin
      {dma_done_out, wait_evt_out, wait_int_out} <= go_in;
    end
  end
endmodule : core_dma_model

// ==== tb/power_clock_properties.sv ====
`timescale 1ns/1ps
module power_clock_checker
  import power_clock_pkg::*;
(
  // clock, reset, wait request and wake sources
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        wait_interrupt_instruction_in,
  input wire logic [31:0] irq_in,
  input wire logic        nmi_in,
  input wire logic        dma_done_in,
  // wake event, enables and mode
  input wire logic        wake_event_out,
  input wire logic        core_clk_en_out,
  input wire logic        apb_clk_en_out,
  input wire logic [1:0]  power_mode_out
);
  // ----------------
  // mode and clock relations
  // ----------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // enables lag the mode by one cycle, so the run, deep and core-off checks wait for a settled mode
  property p_run_on; (power_mode_out == MODE_RUN) [*2] |-> core_clk_en_out && apb_clk_en_out;
  endproperty
  a_run_on: assert property (p_run_on) else $error("clock off in run");
  property p_no_off; power_mode_out != 2'h3; endproperty
  a_no_off: assert property (p_no_off) else $error("bad power state");
  property p_light; power_mode_out == MODE_SLEEP |-> apb_clk_en_out; endproperty
  a_light: assert property (p_light) else $error("bus off in sleep");
  property p_deep; (power_mode_out == MODE_DEEP) [*2] |-> !apb_clk_en_out; endproperty
  a_deep: assert property (p_deep) else $error("bus on in deep sleep");
  property p_core_off; (power_mode_out != MODE_RUN) [*2] |-> !core_clk_en_out; endproperty
  a_core_off: assert property (p_core_off) else $error("core clock on asleep");
  property p_wait_int_in; wait_interrupt_instruction_in && power_mode_out == MODE_RUN
    && irq_in == 32'h0 && !nmi_in |=> power_mode_out != MODE_RUN; endproperty
  a_wait_int_in: assert property (p_wait_int_in) else $error("sleep not entered");
  property p_nmi_wake; power_mode_out != MODE_RUN && nmi_in |=> power_mode_out == MODE_RUN;
  endproperty
  a_nmi_wake: assert property (p_nmi_wake) else $error("no wake on nmi");
  property p_event; 1'b1 |=> wake_event_out == $past(dma_done_in); endproperty
  a_event: assert property (p_event) else $error("event not one cycle after dma");
endmodule : power_clock_checker

bind low_power_clock_gating power_clock_checker checker_i (.*);

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import power_clock_pkg::*;
;
  // ----------------
  // bench
  // ----------------
  logic        clk_in = 1'b0, rstn_in = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, nmi = 1'b0;
  logic [2:0]  go = 3'h0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, irq = 32'h0, rdata, exp_q[$];
  logic [14:0] gate_val;
  logic [1:0]  mode;
  logic        s_wi, s_we, done, evt, tick;
  wire  [3:0]  en;
  wire  [14:0] gates;
  int          n_fail = 0, n_compared = 0, i, seed = 32'ha6aa_7a87;
  logic [31:0] cnt;
  always #5 clk_in = ~clk_in;
  core_dma_model partner (.clk_in(clk_in), .rstn_in(rstn_in), .go_in(go),
    .wait_int_out(s_wi), .wait_evt_out(s_we), .dma_done_out(done));
  low_power_clock_gating dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .wait_interrupt_instruction_in(s_wi), .wait_event_instruction_in(s_we),
    .irq_in(irq), .nmi_in(nmi), .dma_done_in(done), .wake_event_out(evt),
    .core_clk_en_out(en[3]), .apb_clk_en_out(en[2]), .ahb_clk_en_out(en[1]),
    .mem_clk_en_out(en[0]), .converter_clock_en_out(gates[0]),
    .sync_serial_clock_en_out(gates[1]), .async_serial_clock_en_out(gates[2]),
    .timer_clock_a_en_out(gates[3]), .timer_clock_b_en_out(gates[4]),
    .pulse_width_clocks_en_out(gates[12:5]), .watchdog_clock_en_out(gates[13]),
    .random_gen_clock_en_out(gates[14]), .sys_clk_tick_out(tick), .power_mode_out(mode));
  task automatic chk(input string n, input logic [31:0] e, s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  // a read notes its expected word; the watcher below pops it when data shows
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (!w) exp_q.push_back(d);
    cyc(1);
    wr <= 1'b0;
    rd <= 1'b0;
    cyc(1);
  endtask : acc
  task automatic pulse(input logic [2:0] v, input int n);
    go <= v;
    cyc(1);
    go <= 3'h0;
    cyc(n);
  endtask : pulse
  task automatic wait_run;
    for (i = 0; i < 20 && mode !== MODE_RUN; i++) cyc(1);
    chk("wake", MODE_RUN, mode);
    if (mode !== MODE_RUN) stop_test();
    cyc(2);
  endtask : wait_run
  // read data is taken mid-cycle, clear of the edge that launches the next word
  always @(negedge clk_in) begin
    if (rd_d) chk("rdata", exp_q.pop_front(), rdata);
    rd_d <= rd;
  end
  initial begin
    cyc(12);
    rstn_in <= 1'b1;
    cyc(1);
    chk("reset", {en, tick, gates}, 20'hf_ffff);
    acc(0, OFS_STATUS, 32'h0);
    acc(0, OFS_IRQ_ENABLE, IRQ_EN_RESET);
    acc(0, 8'h14, 32'h0);
    gate_val = 15'($random(seed));
    acc(1, OFS_PCLK_GATE, {17'h0, gate_val});
    chk("gates", gate_val, gates);
    acc(0, OFS_PCLK_GATE, {17'h0, gate_val});
    acc(1, OFS_SLEEP_CTRL, 32'h0);
    pulse(3'h1, 3);
    chk("light", {mode, en}, {MODE_SLEEP, 4'h7});
    irq <= 32'h1 << ($random(seed) & 31);
    wait_run();
    chk("resume", {en, gates}, {4'hf, gate_val});
    irq <= 32'h0;
    acc(1, OFS_SLEEP_CTRL, 32'h1);
    pulse(3'h2, 3);
    chk("deep", {mode, en}, {MODE_DEEP, 4'h0});
    pulse(3'h4, 1);
    chk("event", 1'b1, evt);
    wait_run();
    acc(0, OFS_STATUS, 32'h4);
    pulse(3'h2, 3);
    chk("fall through", MODE_RUN, mode);
    acc(0, OFS_STATUS, 32'h0);
    acc(1, OFS_IRQ_ENABLE, 32'h0);
    pulse(3'h1, 3);
    irq <= 32'hffff_ffff;
    cyc(4);
    chk("masked", MODE_DEEP, mode);
    nmi <= 1'b1;
    wait_run();
    nmi <= 1'b0;
    acc(1, OFS_CLK_DIV, 32'h3);
    acc(0, OFS_CLK_DIV, 32'h3);
    cnt = 0;
    repeat (8) begin
      cyc(1);
      cnt += tick;
    end
    chk("ticks", 32'h2, cnt);
    stop_test();
  end
endmodule : testbench

// ==== verilog/low_power_clock_gating.sv ====
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// Behaviour
// - reset enters run mode, every clock on
// - only sleep and deep sleep, no power-off
// - depth bit picks core-only or core, bus and memory stop
// - event wakes core after wait-event entry
// - finished DMA transfer raises a wake event
// - peripheral gates change freely in run mode
// - separate gate per listed peripheral clock
// - software divider slows system clocks
// - one event line beside irq and nmi
module low_power_clock_gating
  import power_clock_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  // register port
  input  wire logic [ADDR_W-1:0]     addr_in,
  input  wire logic [31:0]           wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [31:0]           rdata_out,
  // core sleep requests and wake sources
  input  wire logic                  wait_interrupt_instruction_in,
  input  wire logic                  wait_event_instruction_in,
  input  wire logic [IRQ_W-1:0]      irq_in,
  input  wire logic                  nmi_in,
  input  wire logic                  dma_done_in,
  // event toward the core
  output logic                       wake_event_out,
  // clock enables, divider tick and power mode
  output logic                       core_clk_en_out,
  output logic                       apb_clk_en_out,
  output logic                       ahb_clk_en_out,
  output logic                       mem_clk_en_out,
  output logic                       converter_clock_en_out,
  output logic                       sync_serial_clock_en_out,
  output logic                       async_serial_clock_en_out,
  output logic                       timer_clock_a_en_out,
  output logic                       timer_clock_b_en_out,
  output logic      [PWM_COUNT-1:0]  pulse_width_clocks_en_out,
  output logic                       watchdog_clock_en_out,
  output logic                       random_gen_clock_en_out,
  output logic                       sys_clk_tick_out,
  output logic      [1:0]            power_mode_out
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic                  sleep_depth_select;
  logic [GATE_COUNT-1:0] pclk_gate;
  logic [DIV_W-1:0]      clk_div;
  logic [IRQ_W-1:0]      irq_enable;
  power_mode_e           mode;
  logic                  entered_by_event;
  logic                  wake_pending;
  logic [DIV_W-1:0]      div_count;
  logic                  wake_irq;
  logic                  wake_evt;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sleep_depth_select <= 1'b0;
      pclk_gate          <= PCLK_RESET;
      clk_div            <= DIV_RESET;
      irq_enable         <= IRQ_EN_RESET;
    end else if (wr_in) begin
      if (hit(addr_in, OFS_SLEEP_CTRL)) begin
        sleep_depth_select <= wdata_in[BIT_DEPTH];
      end
      if (hit(addr_in, OFS_PCLK_GATE)) begin
        pclk_gate <= wdata_in[GATE_COUNT-1:0];
      end
      if (hit(addr_in, OFS_CLK_DIV)) begin
        clk_div <= wdata_in[DIV_W-1:0];
      end
      if (hit(addr_in, OFS_IRQ_ENABLE)) begin
        irq_enable <= wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      case (addr_in)
        OFS_SLEEP_CTRL: rdata_out <= {31'h0000_0000, sleep_depth_select};
        OFS_PCLK_GATE:  rdata_out <= {17'h0_0000, pclk_gate};
        OFS_CLK_DIV:    rdata_out <= {28'h000_0000, clk_div};
        OFS_STATUS:     rdata_out <= {29'h0000_0000, wake_pending, mode};
        OFS_IRQ_ENABLE: rdata_out <= irq_enable;
        default:        rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // wake sources
  // ---------------------------------------------------------------
  // a finished transfer is held until the core sleeps or takes it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_pending <= 1'b0;
    end else if (dma_done_in) begin
      wake_pending <= 1'b1;
    end else if (mode != MODE_RUN || wait_event_instruction_in) begin
      wake_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_event_out <= 1'b0;
    end else begin
      wake_event_out <= dma_done_in;
    end
  end

  assign wake_irq = |(irq_in & irq_enable) | nmi_in;
  assign wake_evt = dma_done_in | wake_pending;

  // ---------------------------------------------------------------
  // power mode
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode             <= MODE_RUN;
      entered_by_event <= 1'b0;
    end else begin
      case (mode)
        MODE_RUN: begin
          // pending event makes wait-event fall straight through
          if (wait_event_instruction_in && !wake_evt) begin
            mode             <= sleep_depth_select ? MODE_DEEP : MODE_SLEEP;
            entered_by_event <= 1'b1;
          end else if (wait_interrupt_instruction_in && !wake_irq) begin
            mode             <= sleep_depth_select ? MODE_DEEP : MODE_SLEEP;
            entered_by_event <= 1'b0;
          end
        end
        MODE_SLEEP, MODE_DEEP: begin
          if (entered_by_event ? (wake_evt || wake_irq) : wake_irq) begin
            mode <= MODE_RUN;
          end
        end
        default: mode <= MODE_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // clock enables
  // ---------------------------------------------------------------
  // enables are registered so the downstream latch-based gates see
  // a clean level; restart is therefore glitch-free
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_clk_en_out <= 1'b1;
      apb_clk_en_out  <= 1'b1;
      ahb_clk_en_out  <= 1'b1;
      mem_clk_en_out  <= 1'b1;
    end else begin
      core_clk_en_out <= (mode == MODE_RUN);
      apb_clk_en_out  <= (mode != MODE_DEEP);
      ahb_clk_en_out  <= (mode != MODE_DEEP);
      mem_clk_en_out  <= (mode != MODE_DEEP);
    end
  end

  // peripheral gates are untouched by sleep, so settings survive it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      converter_clock_en_out    <= 1'b1;
      sync_serial_clock_en_out  <= 1'b1;
      async_serial_clock_en_out <= 1'b1;
      timer_clock_a_en_out      <= 1'b1;
      timer_clock_b_en_out      <= 1'b1;
      pulse_width_clocks_en_out <= '1;
      watchdog_clock_en_out     <= 1'b1;
      random_gen_clock_en_out   <= 1'b1;
    end else begin
      converter_clock_en_out    <= pclk_gate[BIT_CONVERTER];
      sync_serial_clock_en_out  <= pclk_gate[BIT_SYNC_SER];
      async_serial_clock_en_out <= pclk_gate[BIT_ASYNC_SER];
      timer_clock_a_en_out      <= pclk_gate[BIT_TIMER_A];
      timer_clock_b_en_out      <= pclk_gate[BIT_TIMER_B];
      pulse_width_clocks_en_out <= pclk_gate[BIT_PWM_LO +: PWM_COUNT];
      watchdog_clock_en_out     <= pclk_gate[BIT_WATCHDOG];
      random_gen_clock_en_out   <= pclk_gate[BIT_RANDOM];
    end
  end

  // ---------------------------------------------------------------
  // system clock divider: one tick every clk_div+1 cycles
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_count        <= '0;
      sys_clk_tick_out <= 1'b1;
    end else begin
      if (div_count >= clk_div) begin
        div_count        <= '0;
        sys_clk_tick_out <= 1'b1;
      end else begin
        div_count        <= div_count + 1'b1;
        sys_clk_tick_out <= 1'b0;
      end
    end
  end

  assign power_mode_out = mode;

endmodule : low_power_clock_gating

// ==== verilog/power_clock_pkg.sv ====
package power_clock_pkg;
  // ---------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_SLEEP_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_PCLK_GATE   = 8'h04;
  localparam logic [7:0]  OFS_CLK_DIV     = 8'h08;
  localparam logic [7:0]  OFS_STATUS      = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h10;

  // ---------------------------------------------------------------
  // peripheral gate bit positions
  // ---------------------------------------------------------------
  localparam int          GATE_COUNT      = 15;
  localparam int          BIT_CONVERTER   = 0;
  localparam int          BIT_SYNC_SER    = 1;
  localparam int          BIT_ASYNC_SER   = 2;
  localparam int          BIT_TIMER_A     = 3;
  localparam int          BIT_TIMER_B     = 4;
  localparam int          BIT_PWM_LO      = 5;
  localparam int          PWM_COUNT       = 8;
  localparam int          BIT_WATCHDOG    = 13;
  localparam int          BIT_RANDOM      = 14;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          BIT_DEPTH       = 0;
  localparam int          DIV_W           = 4;
  localparam int          IRQ_W           = 32;
  localparam logic [14:0] PCLK_RESET      = 15'h7FFF;
  localparam logic [3:0]  DIV_RESET       = 4'h0;
  localparam logic [31:0] IRQ_EN_RESET    = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } power_mode_e;
endpackage : power_clock_pkg
